// File: dbs_pkg.sv
// Shared constants and decode helpers for the data bus steering block.
package dbs_pkg;

    localparam int          DBS_WORD_W      = 32;
    localparam int          DBS_BUF_DEPTH   = 2;
    localparam int          DBS_SYNC_STAGES = 2;
    localparam int          DBS_CHAIN_W     = 4;
    localparam int          DBS_RD_DELAY    = 2;

    localparam logic [31:0] DBS_ZERO_WORD   = 32'h0000_0000;
    localparam logic [3:0]  DBS_CHAIN_A     = 4'h0;
    localparam logic [3:0]  DBS_CHAIN_B     = 4'h4;
    localparam logic [3:0]  DBS_CHAIN_C     = 4'h8;

    localparam logic        DBS_RST_BUS_DIS = 1'b0;
    localparam logic        DBS_RST_OE_B    = 1'b1;
    localparam logic        DBS_RST_VALID   = 1'b0;

    // True when the selected scan chain is one that isolates the data bus.
    function automatic logic dbs_chain_hit(input logic [3:0] chain);
        dbs_chain_hit = (chain == DBS_CHAIN_A) || (chain == DBS_CHAIN_B) || (chain == DBS_CHAIN_C);
    endfunction

endpackage

// File: dbs_stream_if.sv
// Valid and ready word stream carried between the steering block's modules.
`timescale 1ns/1ps
interface dbs_stream_if #(
    parameter int W = 32
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// File: dbs_sync.sv
// Multi-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module dbs_sync
    import dbs_pkg::*;
#(
    parameter int W      = 1,
    parameter int STAGES = DBS_SYNC_STAGES
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage [STAGES];

    // Only the next stage reads each flip-flop, so metastability cannot leak sideways.
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            always_ff @(posedge core_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    stage[g] <= '0;
                end else if (ce_in) begin
                    if (g == 0) begin
                        stage[g] <= async_in;
                    end else begin
                        stage[g] <= stage[(g == 0) ? 0 : g-1];
                    end
                end
            end
        end
    endgenerate

    assign sync_out = stage[STAGES-1];

endmodule

// File: dbs_fifo2.sv
// Small skid buffer that holds write words while the memory side stalls.
`timescale 1ns/1ps
module dbs_fifo2
    import dbs_pkg::*;
#(
    parameter int W     = DBS_WORD_W,
    parameter int DEPTH = DBS_BUF_DEPTH
) (
    input  wire logic    core_clk_in,
    input  wire logic    rst_b_in,
    input  wire logic    ce_in,
    dbs_stream_if.dst    fill,
    dbs_stream_if.src    drain
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic          room;
    logic          push;
    logic          pop;
    logic [CW-1:0] next_count;

    assign push        = fill.valid && room;
    assign pop         = drain.valid && drain.ready;
    assign fill.ready  = room;
    assign drain.valid = (count != '0);
    assign drain.data  = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= '0;
            room  <= 1'b1;
        end else if (ce_in) begin
            count <= next_count;
            room  <= (next_count != FULL_CNT);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce_in) begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PW'(1);
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (ce_in && push) begin
            mem[wr_ptr] <= fill.data;
        end
    end

endmodule

// File: dbs_steer.sv
// Data bus steering between the core's word streams and the memory data pins.
`timescale 1ns/1ps
module dbs_steer
    import dbs_pkg::*;
#(
    parameter int W = DBS_WORD_W
) (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_b_in,
    input  wire logic                   ce_in,
    input  wire logic                   tck_in,
    input  wire logic                   intest_sel_in,
    input  wire logic [DBS_CHAIN_W-1:0] scan_chain_in,
    input  wire logic                   split_bus_select_in,
    input  wire logic                   data_out_enable_in,
    input  wire logic [W-1:0]           data_bus_in,
    input  wire logic [W-1:0]           data_in_bus_in,
    input  wire logic                   mem_read_in,
    input  wire logic                   mem_write_in,
    input  wire logic                   wr_valid_in,
    input  wire logic [W-1:0]           wr_data_in,
    output logic                        wr_ready_out,
    output logic                        rd_valid_out,
    output logic      [W-1:0]           rd_data_out,
    output logic      [W-1:0]           data_bus_out,
    output logic                        data_bus_oe_b_out,
    output logic      [W-1:0]           data_out_bus_out,
    output logic                        scan_bus_disable_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    localparam int TW = 2 + DBS_CHAIN_W;
    localparam int PW = 2 + 2 * W;

    logic [TW-1:0]          test_sync;
    logic [PW-1:0]          pin_sync;
    logic                   tck_s;
    logic                   tck_d;
    logic                   intest_s;
    logic [DBS_CHAIN_W-1:0] chain_s;
    logic                   split_s;
    logic                   dbe_s;
    logic [W-1:0]           dbus_s;
    logic [W-1:0]           din_s;
    logic                   tck_fall;

    dbs_sync #(
        .W      (TW),
        .STAGES (DBS_SYNC_STAGES)
    ) u_test_sync (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .ce_in       (ce_in),
        .async_in    ({tck_in, intest_sel_in, scan_chain_in}),
        .sync_out    (test_sync)
    );

    // The selector is static, so passing it through the same two stages costs nothing.
    dbs_sync #(
        .W      (PW),
        .STAGES (DBS_SYNC_STAGES)
    ) u_pin_sync (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .ce_in       (ce_in),
        .async_in    ({split_bus_select_in, data_out_enable_in, data_bus_in, data_in_bus_in}),
        .sync_out    (pin_sync)
    );

    assign {tck_s, intest_s, chain_s}       = test_sync;
    assign {split_s, dbe_s, dbus_s, din_s}  = pin_sync;
    assign tck_fall                         = tck_d && !tck_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Scan bus disable, updated only on a test clock falling edge.

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tck_d <= 1'b0;
        end else if (ce_in) begin
            tck_d <= tck_s;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scan_bus_disable_out <= DBS_RST_BUS_DIS;
        end else if (ce_in && tck_fall) begin
            scan_bus_disable_out <= intest_s && dbs_chain_hit(chain_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write path through the two-entry buffer.

    dbs_stream_if #(.W(W)) wr_fill ();
    dbs_stream_if #(.W(W)) wr_drain ();

    logic         pop;
    logic [W-1:0] wr_word;
    logic [W-1:0] next_word;

    assign wr_fill.valid  = wr_valid_in;
    assign wr_fill.data   = wr_data_in;
    assign wr_ready_out   = wr_fill.ready;
    assign wr_drain.ready = mem_write_in;
    assign pop            = wr_drain.valid && mem_write_in;
    assign next_word      = pop ? wr_drain.data : wr_word;

    dbs_fifo2 #(
        .W     (W),
        .DEPTH (DBS_BUF_DEPTH)
    ) u_wr_buf (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .ce_in       (ce_in),
        .fill        (wr_fill),
        .drain       (wr_drain)
    );

    // The word is held until the next write pops, so it outlives the sample edge.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_word      <= DBS_ZERO_WORD;
            data_bus_out <= DBS_ZERO_WORD;
        end else if (ce_in) begin
            wr_word      <= next_word;
            data_bus_out <= next_word;
        end
    end

    // The bidirectional bus is driven in either mode; only reads and a low enable release it.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            data_bus_oe_b_out <= DBS_RST_OE_B;
        end else if (ce_in) begin
            data_bus_oe_b_out <= mem_read_in || !dbe_s;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            data_out_bus_out <= DBS_ZERO_WORD;
        end else if (ce_in) begin
            if (split_s && dbe_s) begin
                data_out_bus_out <= next_word;
            end else begin
                data_out_bus_out <= DBS_ZERO_WORD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path, aligned with the synchronised data pins.

    // Picks the word from the bus that the static selector has put in use.
    function automatic logic [W-1:0] read_source(input logic split, input logic [W-1:0] dbus,
                                                 input logic [W-1:0] din);
        read_source = split ? din : dbus;
    endfunction

    logic [DBS_RD_DELAY-1:0] rd_pipe;
    logic                    rd_take;

    assign rd_take = rd_pipe[DBS_RD_DELAY-1];

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_pipe <= '0;
        end else if (ce_in) begin
            rd_pipe <= {rd_pipe[DBS_RD_DELAY-2:0], mem_read_in};
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_valid_out <= DBS_RST_VALID;
            rd_data_out  <= DBS_ZERO_WORD;
        end else if (ce_in) begin
            rd_valid_out <= rd_take;
            if (rd_take) begin
                // The unused bus is never looked at, so a floating pin cannot corrupt a read.
                rd_data_out <= read_source(split_s, dbus_s, din_s);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk_in iff ce_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence seq_tck_fall;
        tck_d && !tck_s;
    endsequence

    sequence seq_test_hit;
        intest_s && dbs_chain_hit(chain_s);
    endsequence

    sequence seq_read_taken;
        rd_take ##1 rd_valid_out;
    endsequence

    // Sequences name the steps of a transfer so that several checks can share them.
    sequence seq_test_miss;
        !(intest_s && dbs_chain_hit(chain_s));
    endsequence

    sequence seq_read_req;
        mem_read_in;
    endsequence

    sequence seq_write_pop;
        pop;
    endsequence

    sequence seq_pop_shown;
        pop && split_s && dbe_s;
    endsequence

    chk_bus_dis_set: assert property (seq_tck_fall and seq_test_hit |=> scan_bus_disable_out)
        else $error("scan bus disable not raised for an isolating chain");

    chk_bus_dis_clear: assert property (seq_tck_fall and seq_test_miss |=> !scan_bus_disable_out)
        else $error("scan bus disable not cleared");

    chk_bus_dis_edge: assert property ($changed(scan_bus_disable_out) |-> $past(tck_fall))
        else $error("scan bus disable changed without a test clock fall");

    chk_unibus_zero: assert property (!split_s ##1 !$past(split_s) |-> data_out_bus_out == DBS_ZERO_WORD)
        else $error("output bus not zero in bidirectional mode");

    chk_unibus_gate: assert property (!dbe_s |=> data_out_bus_out == DBS_ZERO_WORD)
        else $error("output bus not suppressed with output enable low");

    chk_unibus_enable: assert property (data_out_bus_out != DBS_ZERO_WORD |-> $past(split_s && dbe_s))
        else $error("output bus carried data without enable and split mode");

    chk_bidir_release: assert property (mem_read_in || !dbe_s |=> data_bus_oe_b_out)
        else $error("bidirectional bus driven during read or with enable low");

    chk_bidir_drive: assert property (!mem_read_in && dbe_s |=> !data_bus_oe_b_out)
        else $error("bidirectional bus released outside a read");

    chk_write_hold: assert property (!pop |=> $stable(data_bus_out))
        else $error("write data changed without a new write");

    chk_split_read: assert property (rd_take && split_s |=> rd_valid_out && rd_data_out == $past(din_s))
        else $error("split read did not take the input bus");

    chk_bidir_read: assert property (seq_read_taken |-> rd_data_out == $past(split_s ? din_s : dbus_s))
        else $error("read word taken from the wrong bus");

    chk_bus_dis_hold: assert property (!tck_fall |=> $stable(scan_bus_disable_out))
        else $error("scan bus disable moved between test clock falls");

    chk_read_latency: assert property (seq_read_req |-> ##3 rd_valid_out)
        else $error("read word not delivered three cycles after the request");

    chk_read_asked: assert property (rd_valid_out |-> $past(mem_read_in, 3))
        else $error("read word delivered without a request");

    chk_read_pulse: assert property (rd_valid_out && !rd_take |=> !rd_valid_out)
        else $error("read valid stood longer than one cycle");

    chk_read_hold: assert property (!rd_take |=> $stable(rd_data_out))
        else $error("read word changed without a new read");

    chk_bidir_data: assert property (seq_write_pop |=> data_bus_out == $past(wr_drain.data))
        else $error("bidirectional bus does not show the popped word");

    chk_unibus_data: assert property (seq_pop_shown |=> data_out_bus_out == $past(wr_drain.data))
        else $error("output bus does not show the popped word");

    // A steady enable and no pop must leave the output bus word where it is.
    chk_unibus_hold: assert property (!pop && $stable(split_s && dbe_s) |=> $stable(data_out_bus_out))
        else $error("output bus word changed without a new write");

    chk_ready_return: assert property (!wr_ready_out && pop |=> wr_ready_out)
        else $error("buffer room not returned after a pop");

    // This check names its own clock, since the default one skips the frozen cycles.
    chk_enable_freeze: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        !ce_in |=> $stable(scan_bus_disable_out) && $stable(data_bus_out) && $stable(rd_valid_out))
        else $error("state moved while the clock enable was low");

endmodule

// File: dbs_mem_model.sv
// Memory system model that drives the data pins read by the steering block.
`timescale 1ns/1ps
module dbs_mem_model
    import dbs_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        split_in,
    input  wire logic        mem_read_in,
    input  wire logic [31:0] rd_word_in,
    input  wire logic [31:0] dev_data_in,
    input  wire logic        dev_oe_b_in,
    output logic      [31:0] bus_out,
    output logic      [31:0] din_out
);
    logic [31:0] junk = 32'h5a5a_1234;

    // A released pin shows a changing pattern, so a stale word can never pass for read data.
    always @(posedge core_clk_in) begin
        junk <= {junk[30:0], ~junk[31]} ^ 32'h0f0f_a5a5;
    end

    always_comb begin
        if (split_in) begin
            bus_out = junk;
        end else if (mem_read_in) begin
            bus_out = rd_word_in;
        end else if (!dev_oe_b_in) begin
            bus_out = dev_data_in;
        end else begin
            bus_out = junk;
        end
        if (!split_in) begin
            din_out = DBS_ZERO_WORD;
        end else begin
            din_out = mem_read_in ? rd_word_in : junk;
        end
    end
endmodule

// File: tb_top.sv
// Self-checking bench for the data bus steering block.
`timescale 1ns/1ps
module tb_top
    import dbs_pkg::*;
;
    logic        clk = 0, rst_b = 0, tck = 0, intest = 0, split = 0, en = 0;
    logic        mrd = 0, mwr = 0, wv = 0, prev = 0, exp_d = 0, ce = 1;
    logic [3:0]  chain = 0;
    logic [31:0] wd = 0, rword = 0, last = 0, bus, din, rd_data, dbo, dob;
    logic        wr_ready, rd_valid, oe_b, sbd;
    logic [31:0] wq[$];
    int          mismatches = 0, n_checks = 0, seed = 58;

    always #10 clk = ~clk;

    dbs_steer uut (.core_clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .tck_in(tck),
        .intest_sel_in(intest), .scan_chain_in(chain), .split_bus_select_in(split),
        .data_out_enable_in(en), .data_bus_in(bus), .data_in_bus_in(din), .mem_read_in(mrd),
        .mem_write_in(mwr), .wr_valid_in(wv), .wr_data_in(wd), .wr_ready_out(wr_ready),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data), .data_bus_out(dbo),
        .data_bus_oe_b_out(oe_b), .data_out_bus_out(dob), .scan_bus_disable_out(sbd));

    dbs_mem_model mem_model (.core_clk_in(clk), .split_in(split), .mem_read_in(mrd),
        .rd_word_in(rword), .dev_data_in(dbo), .dev_oe_b_in(oe_b), .bus_out(bus), .din_out(din));

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_word({31'h0, got}, {31'h0, exp}, what);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // The selector only changes under reset, since it must stay static in operation.
    task automatic reset_to(input logic s, input logic e);
        rst_b = 0;
        split = s;
        en = e;
        repeat (20) @(negedge clk);
        cmp_bit(oe_b, 1'b1, "reset oe_b");
        cmp_bit(wr_ready, 1'b1, "reset ready");
        cmp_word(dob, DBS_ZERO_WORD, "reset out bus");
        rst_b = 1;
        repeat (4) @(negedge clk);
    endtask

    task automatic do_writes(input logic s, input logic e);
        logic acc;
        wv = 1;
        for (int k = 0; k < 3; k++) begin
            wd = 32'($random(seed));
            if (wr_ready === 1'b1) begin
                wq.push_back(wd);
            end
            @(negedge clk);
        end
        cmp_word(32'(wq.size()), 32'd2, "buffer fill");
        cmp_bit(wr_ready, 1'b0, "full ready");
        // The refused word stays offered and is taken once a pop frees a slot.
        mwr = 1;
        repeat (3) begin
            acc = wv && (wr_ready === 1'b1);
            if (acc) begin
                wq.push_back(wd);
            end
            @(negedge clk);
            if (acc) begin
                wv = 0;
            end
            last = wq.pop_front();
            cmp_word(dbo, last, "bidir word");
            cmp_word(dob, (s && e) ? last : DBS_ZERO_WORD, "out bus");
            cmp_bit(oe_b, !e, "write oe_b");
        end
        @(negedge clk);
        mwr = 0;
        cmp_word(dbo, last, "empty pop");
        cmp_bit(wr_ready, 1'b1, "drained ready");
    endtask

    task automatic do_read;
        logic [31:0] w;
        w = 32'($random(seed));
        rword = w;
        mrd = 1;
        @(negedge clk);
        cmp_bit(oe_b, 1'b1, "read oe_b");
        mrd = 0;
        rword = ~w;
        @(negedge clk);
        cmp_bit(oe_b, !en, "after read oe_b");
        @(negedge clk);
        cmp_bit(rd_valid, 1'b1, "read valid");
        cmp_word(rd_data, w, "read word");
        @(negedge clk);
        cmp_bit(rd_valid, 1'b0, "valid pulse");
    endtask

    initial begin
        for (int m = 0; m < 4; m++) begin
            reset_to(m[1], m[0]);
            do_writes(m[1], m[0]);
            do_read();
            do_read();
            $display("test mode %0d done", m);
        end
        for (int c = 0; c < 32; c++) begin
            tck = 1;
            chain = c[3:0];
            intest = c[4];
            exp_d = c[4] && (c[3:0] == 0 || c[3:0] == 4 || c[3:0] == 8);
            repeat (5) @(negedge clk);
            cmp_bit(sbd, prev, "hold before fall");
            tck = 0;
            repeat (6) @(negedge clk);
            cmp_bit(sbd, exp_d, "scan disable");
            prev = exp_d;
        end
        $display("test scan disable done");
        chain = 4'h4;
        intest = 1;
        tck = 1;
        repeat (5) @(negedge clk);
        ce = 0;
        tck = 0;
        repeat (6) @(negedge clk);
        cmp_bit(sbd, prev, "frozen by enable");
        ce = 1;
        repeat (6) @(negedge clk);
        cmp_bit(sbd, 1'b1, "scan disable after freeze");
        $display("test clock enable done");
        complete_run();
    end

    // About 525 cycles are expected, so this span only trips on a hang.
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule
